// ---- design/nmx_exec.sv ----
// Purpose : executes saturating negative multiply-accumulate, the or family and interrupt returns
// Assumes : operand values arrive from the register file on the same clock, indexed by the
//           instruction fields; the caller forwards pending flag writes into i_summary_flag
// Notes   : every result is registered, one cycle after the instruction is taken
`timescale 1ns/1ns

module nmx_exec
    import nmx_pkg::*;
(
    // clock and reset
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RST,
    // instruction issue
    input  wire logic        I_VALID,
    input  wire logic [0:31] I_INSTR,
    // operand values read from the general registers
    input  wire logic [0:31] I_SOURCE_VALUE_REG,
    input  wire logic [0:31] I_FIRST_SRC_REG,
    input  wire logic [0:31] I_SECOND_OPERAND_REG,
    // machine state and save/restore registers
    input  wire logic [0:31] I_MACHINE_STATE_REG,
    input  wire logic [0:31] I_SAVE_RESTORE_PC,
    input  wire logic [0:31] I_SAVE_RESTORE_STATE,
    input  wire logic [0:31] I_CRITICAL_SAVE_PC,
    input  wire logic [0:31] I_CRITICAL_SAVE_STATE,
    input  wire logic        I_SUMMARY_FLAG,
    // register write-back
    output logic             O_WB_EN,
    output logic      [0:4]  O_WB_IDX,
    output logic      [0:31] O_WB_DATA,
    // condition and exception flags
    output logic             O_CR0_EN,
    output logic      [0:3]  O_CONDITION_FIELD_ZERO,
    output logic             O_XER_EN,
    output logic             O_XER_SUMMARY,
    output logic             O_WRAP_FLAG,
    // machine state and fetch redirect
    output logic             O_MSR_EN,
    output logic      [0:31] O_MACHINE_STATE_REG,
    output logic             O_REDIRECT,
    output logic      [0:31] O_NEXT_FETCH_ADDRESS,
    output logic             O_BUSY,
    output logic             O_PROG_EXC
);

    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    typedef struct packed {
        nmx_state_e  st;
        logic        busy;
        logic        wb_en;
        logic [0:4]  wb_idx;
        logic [0:31] wb_data;
        logic        cr_en;
        logic [0:3]  cr0;
        logic        xer_en;
        logic        xer_so;
        logic        xer_ov;
        logic        msr_en;
        logic [0:31] machine_state_reg;
        logic        redir;
        logic [0:31] nfa;
        logic        prog;
    } nmx_state_s;

    nmx_state_s s_reg;
    nmx_state_s s_next;

    nmx_mac_if mac ();

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [0:5]  opcode;
    logic [0:9]  xo_x;
    logic [0:8]  xo_xo;
    logic        rec_bit;
    logic        oe_bit;
    logic [0:15] unsigned_immediate;
    logic        take;
    logic        is_mac;
    logic        is_nor;
    logic        is_or;
    logic        is_orc;
    logic        is_ori;
    logic        is_oris;
    logic        is_ret_crit;
    logic        is_ret_norm;
    logic        user_mode;

    // fields sliced with bit 0 as msb
    assign opcode             = I_INSTR[F_OPCODE +: 6];
    assign xo_x               = I_INSTR[F_XO_X +: 10];
    assign xo_xo              = I_INSTR[F_XO_XO +: 9];
    assign rec_bit            = I_INSTR[F_RECORD];
    assign oe_bit             = I_INSTR[F_OE];
    assign unsigned_immediate = I_INSTR[F_IMM +: 16];
    assign user_mode          = I_MACHINE_STATE_REG[MSR_USER_BIT];

    // a slot presented during the drain cycle is discarded
    assign take = I_VALID && (s_reg.st == NMX_ST_RUN);

    assign is_mac      = (opcode == OP_MAC_GROUP) && (xo_xo == XO_NMAC_LL_S);
    assign is_nor      = (opcode == OP_X_GROUP) && (xo_x == XO_NOR);
    assign is_or       = (opcode == OP_X_GROUP) && (xo_x == XO_OR);
    assign is_orc      = (opcode == OP_X_GROUP) && (xo_x == XO_ORC);
    assign is_ori      = (opcode == OP_OR_IMM);
    assign is_oris     = (opcode == OP_OR_IMM_SH);
    // only opcode and xo decoded; reserved bits ignored
    assign is_ret_crit = (opcode == OP_XL_GROUP) && (xo_x == XO_RET_CRIT);
    assign is_ret_norm = (opcode == OP_XL_GROUP) && (xo_x == XO_RET_NORM);

    // ----------------------------------------------------------------
    // multiply-accumulate unit
    // ----------------------------------------------------------------
    // low halfwords, old destination as accumulator
    assign mac.a_half = I_FIRST_SRC_REG[HALF_LOW +: 16];
    assign mac.b_half = I_SECOND_OPERAND_REG[HALF_LOW +: 16];
    assign mac.acc    = I_SOURCE_VALUE_REG;

    nmx_mac_unit u_mac (
        .mac (mac)
    );

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic [0:31] res;
    logic        rec;
    logic        so_new;

    // pulse fields default low so each effect lasts exactly one cycle
    always_comb begin
        res         = WORD_RESET;
        rec         = 1'b0;
        so_new      = I_SUMMARY_FLAG;
        s_next      = s_reg;
        s_next.wb_en  = 1'b0;
        s_next.cr_en  = 1'b0;
        s_next.xer_en = 1'b0;
        s_next.msr_en = 1'b0;
        s_next.redir  = 1'b0;
        s_next.prog   = 1'b0;
        s_next.busy   = 1'b0;
        case (s_reg.st)
            NMX_ST_RUN: begin
                s_next.st = NMX_ST_RUN;
            end
            NMX_ST_DRAIN: begin
                // the dropped slot was fetched before the new state took hold
                s_next.st = NMX_ST_RUN;
            end
            default: begin
                s_next.st = NMX_ST_RUN;
            end
        endcase
        if (take) begin
            if (is_mac) begin
                // result or clamp from the unit
                res            = mac.result;
                rec            = rec_bit;
                s_next.wb_en   = 1'b1;
                s_next.wb_idx  = I_INSTR[F_SRC_DEST +: 5];
                if (oe_bit) begin
                    so_new        = I_SUMMARY_FLAG | mac.ovf;
                    s_next.xer_en = 1'b1;
                    s_next.xer_ov = mac.ovf;
                    s_next.xer_so = so_new;
                end
            end else if (is_nor || is_or || is_orc || is_ori || is_oris) begin
                s_next.wb_en  = 1'b1;
                s_next.wb_idx = I_INSTR[F_FIRST_SRC +: 5];
                rec           = rec_bit && !(is_ori || is_oris);
                if (is_nor) begin
                    res = ~(I_SOURCE_VALUE_REG | I_SECOND_OPERAND_REG);
                end else if (is_or) begin
                    res = I_SOURCE_VALUE_REG | I_SECOND_OPERAND_REG;
                end else if (is_orc) begin
                    res = I_SOURCE_VALUE_REG | ~I_SECOND_OPERAND_REG;
                end else if (is_ori) begin
                    res = I_SOURCE_VALUE_REG | {HALF_ZERO, unsigned_immediate};
                end else begin
                    res = I_SOURCE_VALUE_REG | {unsigned_immediate, HALF_ZERO};
                end
            end else if (is_ret_crit || is_ret_norm) begin
                if (user_mode) begin
                    s_next.prog = 1'b1;
                end else begin
                    s_next.msr_en = 1'b1;
                    s_next.machine_state_reg    = is_ret_crit ? I_CRITICAL_SAVE_STATE : I_SAVE_RESTORE_STATE;
                    s_next.redir  = 1'b1;
                    s_next.nfa    = is_ret_crit ? I_CRITICAL_SAVE_PC : I_SAVE_RESTORE_PC;
                    // drain one slot before new-context issue
                    s_next.st     = NMX_ST_DRAIN;
                    s_next.busy   = 1'b1;
                end
            end
        end
        if (s_next.wb_en) begin
            s_next.wb_data = res;
        end
        // sign, zero and summary into field zero
        if (rec) begin
            s_next.cr_en = 1'b1;
            s_next.cr0   = {res[0], !res[0] && (|res), ~(|res), so_new};
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state record
    assign O_WB_EN                = s_reg.wb_en;
    assign O_WB_IDX               = s_reg.wb_idx;
    assign O_WB_DATA              = s_reg.wb_data;
    assign O_CR0_EN               = s_reg.cr_en;
    assign O_CONDITION_FIELD_ZERO = s_reg.cr0;
    assign O_XER_EN               = s_reg.xer_en;
    assign O_XER_SUMMARY          = s_reg.xer_so;
    assign O_WRAP_FLAG            = s_reg.xer_ov;
    assign O_MSR_EN               = s_reg.msr_en;
    assign O_MACHINE_STATE_REG    = s_reg.machine_state_reg;
    assign O_REDIRECT             = s_reg.redir;
    assign O_NEXT_FETCH_ADDRESS   = s_reg.nfa;
    assign O_BUSY                 = s_reg.busy;
    assign O_PROG_EXC             = s_reg.prog;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);

    sequence s_take_mac;
        take && is_mac;
    endsequence

    sequence s_take_ret;
        take && (is_ret_crit || is_ret_norm) && !user_mode;
    endsequence

    a_mac_target: assert property (s_take_mac |=> O_WB_EN && O_WB_IDX == $past(I_INSTR[6:10]))
        else $error("multiply-accumulate wrote the wrong target");

    a_mac_plain_sum: assert property (s_take_mac ##0 !mac.ovf |=>
        O_WB_DATA == 32'($signed($past(I_SOURCE_VALUE_REG)) - $signed($past(I_FIRST_SRC_REG[16:31]))
                         * $signed($past(I_SECOND_OPERAND_REG[16:31]))))
        else $error("multiply-accumulate sum differs from expected");

    a_mac_clamp: assert property (s_take_mac ##0 mac.ovf |=>
        O_WB_DATA == ($past(I_SOURCE_VALUE_REG[0]) ? SAT_MOST_NEG : SAT_MOST_POS))
        else $error("overflowed sum not clamped");

    a_wrap_flags: assert property (s_take_mac |=>
        O_XER_EN == $past(oe_bit) && (!O_XER_EN || O_XER_SUMMARY == ($past(I_SUMMARY_FLAG) | O_WRAP_FLAG)))
        else $error("exception flags update wrong");

    a_record_sign: assert property (O_CR0_EN |->
        O_CONDITION_FIELD_ZERO[0:2] == {O_WB_DATA[0], !O_WB_DATA[0] && (|O_WB_DATA), O_WB_DATA == 32'h0000_0000})
        else $error("condition field disagrees with result");

    a_nor_value: assert property (take && is_nor |=>
        O_WB_DATA == ~($past(I_SOURCE_VALUE_REG) | $past(I_SECOND_OPERAND_REG)))
        else $error("inverted or wrong");

    a_orc_value: assert property (take && is_orc |=>
        O_WB_DATA == ($past(I_SOURCE_VALUE_REG) | ~$past(I_SECOND_OPERAND_REG)))
        else $error("or with complement wrong");

    a_ori_noflags: assert property (take && is_ori |=>
        !O_CR0_EN && O_WB_DATA[0:15] == $past(I_SOURCE_VALUE_REG[0:15]))
        else $error("immediate or touched upper half or flags");

    a_oris_lowhalf: assert property (take && is_oris |=>
        O_WB_DATA[16:31] == $past(I_SOURCE_VALUE_REG[16:31]))
        else $error("shifted immediate or touched lower half");

    a_return_path: assert property (s_take_ret |=> O_REDIRECT && O_MSR_EN &&
        O_NEXT_FETCH_ADDRESS == ($past(is_ret_crit) ? $past(I_CRITICAL_SAVE_PC) : $past(I_SAVE_RESTORE_PC)))
        else $error("return address not restored");

    a_return_drain: assert property (s_take_ret |=> O_BUSY ##1 (!O_WB_EN && !O_REDIRECT && !O_PROG_EXC))
        else $error("slot after return was not discarded");

    a_user_trap: assert property (take && (is_ret_crit || is_ret_norm) && user_mode |=>
        O_PROG_EXC && !O_REDIRECT && !O_MSR_EN)
        else $error("user-mode return not trapped");

endmodule

// ---- design/nmx_mac_unit.sv ----
// Purpose : saturating negated signed halfword product plus accumulator
// Assumes : operands stable within the cycle
// Notes   : the 33-bit sum is formed explicitly so overflow follows the sign test
`timescale 1ns/1ns
module nmx_mac_unit
    import nmx_pkg::*;
(
    // operand and result carrier
    nmx_mac_if.unit mac
);

    logic [0:31] prod;
    logic [0:31] nprod;
    logic [0:32] temp;

    // ----------------------------------------------------------------
    // product, negation and wide sum
    // ----------------------------------------------------------------
    // negate then accumulate
    always_comb begin
        prod  = 32'($signed(mac.a_half) * $signed(mac.b_half));
        nprod = 32'(-$signed(prod));
        temp  = 33'({nprod[0], nprod} + {mac.acc[0], mac.acc});
    end

    // ----------------------------------------------------------------
    // overflow and clamp
    // ----------------------------------------------------------------
    // same-sign inputs, flipped result
    assign mac.ovf = (nprod[0] == mac.acc[0]) && (mac.acc[0] != temp[1]);

    assign mac.result = mac.ovf ? (mac.acc[0] ? SAT_MOST_NEG : SAT_MOST_POS) : temp[1:32];

endmodule

// ---- inc/nmx_mac_if.sv ----
// Purpose : carries operands and result between the slice and its multiply-accumulate unit
// Assumes : purely combinational path, same clock cycle
// Notes   : halfwords are signed, accumulator is the old destination value
`timescale 1ns/1ns
interface nmx_mac_if;
    logic [0:15] a_half;
    logic [0:15] b_half;
    logic [0:31] acc;
    logic [0:31] result;
    logic        ovf;

    modport issuer (output a_half, output b_half, output acc, input result, input ovf);
    modport unit   (input a_half, input b_half, input acc, output result, output ovf);
endinterface

// ---- inc/nmx_pkg.sv ----
// Purpose : constants shared by the execution slice and its multiply-accumulate unit
// Assumes : big-endian bit numbering, bit 0 is the most significant bit of a word
// Notes   : field positions are given as the index of the leftmost bit of each field
package nmx_pkg;

    // ----------------------------------------------------------------
    // primary and extended opcodes
    // ----------------------------------------------------------------
    localparam logic [0:5] OP_MAC_GROUP  = 6'h04; // 4
    localparam logic [0:5] OP_X_GROUP    = 6'h1F; // 31
    localparam logic [0:5] OP_OR_IMM     = 6'h18; // 24
    localparam logic [0:5] OP_OR_IMM_SH  = 6'h19; // 25
    localparam logic [0:5] OP_XL_GROUP   = 6'h13; // 19
    localparam logic [0:8] XO_NMAC_LL_S  = 9'h1EE; // 494
    localparam logic [0:9] XO_NOR        = 10'h07C; // 124
    localparam logic [0:9] XO_OR         = 10'h1BC; // 444
    localparam logic [0:9] XO_ORC        = 10'h19C; // 412
    localparam logic [0:9] XO_RET_CRIT   = 10'h033; // 51
    localparam logic [0:9] XO_RET_NORM   = 10'h032; // 50

    // ----------------------------------------------------------------
    // instruction field positions (msb index, bit 0 = msb)
    // ----------------------------------------------------------------
    localparam int F_OPCODE     = 0;
    localparam int F_SRC_DEST   = 6;
    localparam int F_FIRST_SRC  = 11;
    localparam int F_SECOND     = 16;
    localparam int F_OE         = 21;
    localparam int F_XO_X       = 21;
    localparam int F_XO_XO      = 22;
    localparam int F_IMM        = 16;
    localparam int F_RECORD     = 31;
    localparam int HALF_LOW     = 16;

    // privilege bit of the machine state: set means user mode
    localparam int MSR_USER_BIT = 17;

    // ----------------------------------------------------------------
    // saturation limits and reset values
    // ----------------------------------------------------------------
    localparam logic [0:31] SAT_MOST_NEG = 32'h8000_0000;
    localparam logic [0:31] SAT_MOST_POS = 32'h7FFF_FFFF;
    localparam logic [0:31] WORD_RESET   = 32'h0000_0000;
    localparam logic [0:15] HALF_ZERO    = 16'h0000;

    // execution state: drain discards the slot fetched under the old state
    typedef enum logic [0:0] {
        NMX_ST_RUN   = 1'h0,
        NMX_ST_DRAIN = 1'h1
    } nmx_state_e;

endpackage

// ---- test/nmx_exec_tb.sv ----
// Purpose : self-checking bench for the execution slice, driven straight at its ports
// Assumes : inputs change at the falling edge, results are read one rising edge later
// Notes   : operand words are kept little-endian here, so bit 31 is the msb (bit 0 at the port)
`timescale 1ns/1ns
module nmx_exec_tb;
    import nmx_pkg::*;

    // ----------------------------------------------------------------
    // expected outputs of one issued instruction
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        wb_en;
        logic [4:0]  idx;
        logic [31:0] data;
        logic        cr_en;
        logic [3:0]  cr;
        logic        xer_en;
        logic        so;
        logic        ov;
        logic        msr_en;
        logic [31:0] machine_state_reg;
        logic [31:0] nfa;
        logic        prog;
        logic        busy;
    } nmx_tb_exp_s;

    logic        clk, rst, valid, summary, wb_en, cr_en, xer_en, xer_so, wrap, msr_en, redir, busy, prog;
    logic [0:31] instr, src_val, first_val, second_val, msr_in, srr_pc, srr_st, crit_pc, crit_st;
    logic [0:31] wb_data, msr_out, nfa;
    logic [0:4]  wb_idx;
    logic [0:3]  cr;
    logic [31:0] seed, r, ins;
    logic [2:0]  k;
    logic        exp_busy;
    int          miscompares, n_tests, i;
    logic [9:0]  xo_tab [3] = '{10'd124, 10'd444, 10'd412};

    nmx_exec u_nmx_exec (
        .I_REF_CLK(clk), .I_RST(rst), .I_VALID(valid), .I_INSTR(instr),
        .I_SOURCE_VALUE_REG(src_val), .I_FIRST_SRC_REG(first_val), .I_SECOND_OPERAND_REG(second_val),
        .I_MACHINE_STATE_REG(msr_in), .I_SAVE_RESTORE_PC(srr_pc), .I_SAVE_RESTORE_STATE(srr_st),
        .I_CRITICAL_SAVE_PC(crit_pc), .I_CRITICAL_SAVE_STATE(crit_st), .I_SUMMARY_FLAG(summary),
        .O_WB_EN(wb_en), .O_WB_IDX(wb_idx), .O_WB_DATA(wb_data), .O_CR0_EN(cr_en),
        .O_CONDITION_FIELD_ZERO(cr), .O_XER_EN(xer_en), .O_XER_SUMMARY(xer_so), .O_WRAP_FLAG(wrap),
        .O_MSR_EN(msr_en), .O_MACHINE_STATE_REG(msr_out), .O_REDIRECT(redir),
        .O_NEXT_FETCH_ADDRESS(nfa), .O_BUSY(busy), .O_PROG_EXC(prog)
    );

    // free-running 125 MHz clock
    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // helpers: random source, encoders, reference model
    // ----------------------------------------------------------------
    // xorshift keeps the random stream repeatable across simulators
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // register form: op, first field, second field, third field, extended code, record bit
    function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] f1, f2, f3,
                                       input logic [9:0] xo, input logic rc);
        return {op, f1, f2, f3, xo, rc};
    endfunction

    // reference model of one instruction; drop models the cycle after a return
    function automatic nmx_tb_exp_s predict(input logic [31:0] n, s, a, b, m, input logic so_in, drop);
        nmx_tb_exp_s     e;
        logic signed [31:0] prod, nprod;
        logic [32:0]     tmp;
        logic [31:0]     res;
        logic [5:0]      op;
        logic [9:0]      xo;
        logic            ov;
        e   = '0;
        op  = n[31:26];
        xo  = n[10:1];
        res = '0;
        ov  = 1'b0;
        if (drop) return e;
        if (op == 6'd4 && xo[8:0] == 9'd494) begin
            prod  = $signed(a[15:0]) * $signed(b[15:0]);
            nprod = -prod;
            tmp   = {nprod[31], nprod} + {s[31], s};
            ov    = (nprod[31] == s[31]) && (s[31] != tmp[31]);
            res   = ov ? {s[31], {31{~s[31]}}} : tmp[31:0];
            e.wb_en  = 1'b1;
            e.idx    = n[25:21];
            e.xer_en = n[10];
        end else if (op == 6'd31 && (xo == 10'd124 || xo == 10'd444 || xo == 10'd412)) begin
            res = (xo == 10'd124) ? ~(s | b) : (xo == 10'd444) ? (s | b) : (s | ~b);
            e.wb_en = 1'b1;
            e.idx   = n[20:16];
        end else if (op == 6'd24 || op == 6'd25) begin
            res = s | ((op == 6'd24) ? {16'h0000, n[15:0]} : {n[15:0], 16'h0000});
            e.wb_en = 1'b1;
            e.idx   = n[20:16];
        end else if (op == 6'd19 && (xo == 10'd50 || xo == 10'd51)) begin
            e.prog   = m[14];
            e.msr_en = !m[14];
            e.busy   = !m[14];
            e.machine_state_reg    = (xo == 10'd51) ? crit_st : srr_st;
            e.nfa    = (xo == 10'd51) ? crit_pc : srr_pc;
        end
        e.data  = res;
        e.ov    = ov;
        e.so    = so_in | ov;
        e.cr_en = e.wb_en && n[0] && op != 6'd24 && op != 6'd25;
        e.cr    = {res[31], !res[31] && res != 0, res == 0, so_in | (e.xer_en & ov)};
        return e;
    endfunction

    // ----------------------------------------------------------------
    // compare tasks and verdict
    // ----------------------------------------------------------------
    task automatic chk_word(input string nm, input logic [31:0] ex, got);
        n_tests++;
        if (got !== ex) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chk_bit(input string nm, input logic ex, got);
        n_tests++;
        if (got !== ex) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", nm, ex, got);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // every output must sit at zero while reset is held
    task automatic chk_quiet();
        chk_word("flags", 32'h0, {14'h0, wb_en, cr_en, xer_en, msr_en, redir, busy, prog, xer_so, wrap, cr, wb_idx});
        chk_word("words", 32'h0, wb_data | msr_out | nfa);
    endtask

    // issue one instruction at the falling edge, compare one rising edge later
    task automatic run(input logic [31:0] n, s, a, b, m, input logic so_in);
        nmx_tb_exp_s e;
        valid      = 1'b1;
        instr      = n;
        src_val    = s;
        first_val  = a;
        second_val = b;
        msr_in     = m;
        summary    = so_in;
        srr_pc     = rnd();
        srr_st     = rnd();
        crit_pc    = rnd();
        crit_st    = rnd();
        e = predict(n, s, a, b, m, so_in, exp_busy);
        @(posedge clk);
        @(negedge clk);
        exp_busy = e.busy;
        chk_bit("wb_en", e.wb_en, wb_en);
        if (e.wb_en) chk_word("wb_idx", {27'h0, e.idx}, {27'h0, wb_idx});
        if (e.wb_en) chk_word("wb_data", e.data, wb_data);
        chk_bit("cr_en", e.cr_en, cr_en);
        if (e.cr_en) chk_word("cr_field", {28'h0, e.cr}, {28'h0, cr});
        chk_bit("xer_en", e.xer_en, xer_en);
        if (e.xer_en) chk_word("xer_bits", {30'h0, e.so, e.ov}, {30'h0, xer_so, wrap});
        chk_bit("msr_en", e.msr_en, msr_en);
        chk_bit("redirect", e.msr_en, redir);
        chk_bit("busy", e.busy, busy);
        chk_bit("prog_exc", e.prog, prog);
        if (e.msr_en) chk_word("msr", e.machine_state_reg, msr_out);
        if (e.msr_en) chk_word("next_fetch", e.nfa, nfa);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {clk, rst, valid, summary, exp_busy} = 5'b01000;
        {instr, src_val, first_val, second_val, msr_in} = '0;
        {srr_pc, srr_st, crit_pc, crit_st} = '0;
        seed        = 32'h0635_e8f5;
        miscompares = 0;
        n_tests     = 0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk_quiet();
        rst = 1'b0;
        $display("test reset done");
        // saturation both ways, no overflow, high halves carry junk, every oe/record mix
        for (k = 0; k < 4; k++) begin
            run(mk(6'd4, 5'd3, 5'd4, 5'd5, {k[1], 9'd494}, k[0]), 32'h7FFF_FFFF, 32'hABCD_8000, 32'h1234_0001, 0, k[0]);
            run(mk(6'd4, 5'd7, 5'd1, 5'd2, {k[1], 9'd494}, k[0]), 32'h8000_0000, 32'h5555_7FFF, 32'hAAAA_7FFF, 0, 0);
            run(mk(6'd4, 5'd9, 5'd8, 5'd6, {k[1], 9'd494}, k[0]), 32'h0000_0000, 32'h0000_8000, 32'hFFFF_8000, 0, 0);
            run(mk(6'd4, 5'd1, 5'd2, 5'd3, {k[1], 9'd494}, k[0]), 32'h0000_0001, 32'hFFFF_0001, 32'h0000_0001, 0, 1);
        end
        $display("test multiply_accumulate done");
        // register or family, record clear and set, then the immediates
        for (k = 0; k < 6; k++)
            run(mk(6'd31, 5'(rnd()), 5'(rnd()), 5'(rnd()), xo_tab[k % 3], k > 2), rnd(), rnd(), rnd(), 0, k[0]);
        run(mk(6'd31, 5'd4, 5'd4, 5'd4, 10'd124, 1), 32'h0000_0000, 0, 32'h0000_0000, 0, 0);
        run({6'd24, 5'd0, 5'd0, 16'h0000}, 32'h0000_0000, 0, 0, 0, 0);
        run({6'd24, 5'd2, 5'd6, 16'hF00D}, 32'h1234_0000, 0, 0, 0, 1);
        run({6'd25, 5'd2, 5'd6, 16'hF00D}, 32'h0000_1234, 0, 0, 0, 1);
        $display("test or_family done");
        // returns: critical, then one dropped behind it, user mode, reserved bits set
        run(mk(6'd19, 5'd0, 5'd0, 5'd0, 10'd51, 0), 0, 0, 0, 32'h0000_0000, 0);
        run(mk(6'd19, 5'd0, 5'd0, 5'd0, 10'd50, 0), 0, 0, 0, 32'h0000_0000, 0);
        run(mk(6'd19, 5'd0, 5'd0, 5'd0, 10'd50, 0), 0, 0, 0, 32'h0000_0000, 0);
        run(mk(6'd31, 5'd1, 5'd2, 5'd3, 10'd444, 1), rnd(), 0, rnd(), 0, 0);
        run(mk(6'd19, 5'd0, 5'd0, 5'd0, 10'd51, 0), 0, 0, 0, 32'h0000_4000, 0);
        run(mk(6'd19, 5'd0, 5'd0, 5'd0, 10'd50, 0), 0, 0, 0, 32'hFFFF_FFFF, 0);
        run(mk(6'd19, 5'h1F, 5'h1F, 5'h1F, 10'd50, 1), 0, 0, 0, 32'h0000_0000, 0);
        run(mk(6'd31, 5'd1, 5'd2, 5'd3, 10'd28, 1), rnd(), rnd(), rnd(), 0, 0);
        run(mk(6'd4, 5'd1, 5'd2, 5'd3, {1'b1, 9'd430}, 1), rnd(), rnd(), rnd(), 0, 0);
        $display("test returns done");
        // random stream over every decoded kind plus stray encodings
        for (i = 0; i < 400; i++) begin
            r   = rnd();
            ins = rnd();
            case (r[2:0])
                3'd0: begin
                    ins[31:26] = 6'd4;
                    ins[9:1]   = 9'd494;
                end
                3'd1, 3'd2, 3'd3: begin
                    ins[31:26] = 6'd31;
                    ins[10:1]  = xo_tab[r[4:3] % 3];
                end
                3'd4: ins[31:26] = 6'd24;
                3'd5: ins[31:26] = 6'd25;
                3'd6: begin
                    ins[31:26] = 6'd19;
                    ins[10:1]  = r[3] ? 10'd51 : 10'd50;
                end
                default: ins[31:26] = r[8:3];
            endcase
            run(ins, rnd(), rnd(), rnd(), rnd(), r[9]);
        end
        $display("test random_stream done");
        // reset in mid-run right behind a return clears every output and the drain
        run(mk(6'd19, 5'd0, 5'd0, 5'd0, 10'd51, 0), 0, 0, 0, 32'h0000_0000, 0);
        rst = 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk_quiet();
        rst      = 1'b0;
        exp_busy = 1'b0;
        run(mk(6'd31, 5'd5, 5'd6, 5'd7, 10'd412, 1), rnd(), 0, rnd(), 0, 1);
        $display("test mid_reset done");
        give_verdict();
    end
endmodule
